// *** hbp_defs.svh ***
`ifndef HBP_DEFS_SVH
`define HBP_DEFS_SVH

// host bus flavour strap codes
`define HBP_MODE_ASYNC   3'h0
`define HBP_MODE_ASYNC2  3'h1
`define HBP_MODE_SYNC    3'h7

// address split: chip decode bits and register bits
`define HBP_SEL_MSB      10
`define HBP_SEL_LSB      8
`define HBP_REG_MSB      7

// reset values
`define HBP_BYTE_RST     8'h00
`define HBP_ADDR_RST     11'h000
`define HBP_CNT_RST      4'h0

// timing, in ns, and derived clock counts
`define HBP_CLK_NS       8
`define HBP_ACK_MAX_NS   90
`define HBP_ACK_MAX_CYC  (`HBP_ACK_MAX_NS / `HBP_CLK_NS)
`define HBP_CS_STB_NS    65
`define HBP_CS_STB_CYC   ((`HBP_CS_STB_NS + `HBP_CLK_NS - 1) / `HBP_CLK_NS)
`define HBP_ACK_DLY_CYC  2

`endif

// *** hbp_pkg.sv ***
package hbp_pkg;

  // strap value of the host bus flavour
  typedef logic [2:0] hbp_mode_t;

  // device end sequencer
  typedef enum logic [1:0] {DEV_IDLE, DEV_ACK, DEV_HOLD} hbp_dev_state_t;

  // host end sequencer
  typedef enum logic [2:0] {HOST_IDLE, HOST_LATCH, HOST_STB, HOST_WAIT, HOST_REL}
    hbp_host_state_t;

endpackage

// *** hbp_bus_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface hbp_bus_if;
  logic [10:0] addr;       // full register address
  logic        cs_n;       // chip select, active low
  logic        ale;        // addr_latch_strobe_pin / transfer_start
  logic        rd_n;       // read_or_strobe_pin
  logic        wr_n;       // write_or_dir_pin
  logic        hclk;       // host_sync_clock
  logic [2:0]  mode_sel;   // host_mode_select strap
  logic        done_n;     // cycle_done_pin / transfer_ack
  logic [7:0]  host_data;  // host data out
  logic        host_oe;    // host drives data
  logic [7:0]  dev_data;   // device data out
  logic        dev_oe;     // device drives data
  logic [7:0]  data_bus;   // resolved data wire

  // resolve the shared data wire; undriven bus floats high
  assign data_bus = dev_oe ? dev_data : (host_oe ? host_data : 8'hFF);

  modport dev (input addr, cs_n, ale, rd_n, wr_n, hclk, mode_sel, data_bus,
               output done_n, dev_data, dev_oe);
  modport host (input done_n, data_bus,
                output addr, cs_n, ale, rd_n, wr_n, hclk, mode_sel, host_data, host_oe);
endinterface
`default_nettype wire

// *** hbp_device.sv ***
// How it works
// - strap 000/001/111 picks bus flavour
// - chip select low enables register access
// - top three address bits decode chip select
// - host gives address, then chip select low; hbp_host drives both in the same cycle
// - sync mode latches address on strobe fall
// - sync direction pin high reads, low writes
// - sync strobe low with select starts cycle
// - sync mode acts on host clock edges
// - sync mode completion shown by ack low
// - without chip select other controls ignored; the address latch follows ale regardless
// - async address latched on strobe falling edge
// - strobe held high gives transparent address
// - async read strobe enables data drivers
// - after read strobe, ready goes low
// - host ends read after ready seen
// - host puts write data before strobe
// - async write strobe takes bus data
// - write stores byte then ready low
// - sync read direction high, ack follows
// - sync read ends by chip select high
`timescale 1ns/1ns
`default_nettype none
`include "hbp_defs.svh"
module hbp_device #(
  parameter int ACK_DLY = `HBP_ACK_DLY_CYC  // cycles from strobe to done, 1..max
) (
  input  wire logic              I_REF_CLK,  // system clock, 125 MHz
  input  wire logic              I_RST_N,    // synchronous reset, active low
  hbp_bus_if.dev                 BUS,        // host bus pins
  input  wire logic [2:0]        I_DEV_SEL,  // chip decode value for addr[10:8]
  output logic                   O_WR_STB,   // one-cycle pulse per stored byte
  output logic [7:0]             O_WR_ADDR,  // register address of stored byte
  output logic [7:0]             O_WR_DATA,  // stored byte
  output hbp_pkg::hbp_mode_t     O_MODE      // captured bus flavour
);
  import hbp_pkg::*;

  logic [7:0]     regs [0:255];   // on-chip register store
  hbp_dev_state_t state_ff;
  hbp_dev_state_t nxt_state;
  hbp_mode_t      mode_ff;
  hbp_mode_t      nxt_mode;
  logic           mode_taken_ff;
  logic           nxt_mode_taken;
  logic [7:0]     alat_ff;
  logic [7:0]     nxt_alat;
  logic           hclk_q_ff;
  logic           wrpin_ff;
  logic           nxt_wrpin;
  logic [3:0]     ack_cnt_ff;
  logic [3:0]     nxt_ack_cnt;
  logic [7:0]     dout_ff;
  logic [7:0]     nxt_dout;
  logic           doe_ff;
  logic           nxt_doe;
  logic           done_n_ff;
  logic           nxt_done_n;
  logic           wstb_ff;
  logic           nxt_wstb;
  logic [7:0]     waddr_ff;
  logic [7:0]     nxt_waddr;
  logic [7:0]     wdata_ff;
  logic [7:0]     nxt_wdata;
  logic           sel;
  logic [7:0]     reg_addr;
  logic           hclk_rise;
  logic           go;
  logic           go_rd;
  logic           go_wrpin;
  logic           ended;
  logic           ack_tick;

  // access qualifiers: select decode, address latch, clock edge
  always_comb
  begin
    sel       = ~BUS.cs_n &&
                (BUS.addr[`HBP_SEL_MSB:`HBP_SEL_LSB] == I_DEV_SEL);
    reg_addr  = BUS.ale ? BUS.addr[`HBP_REG_MSB:0] : alat_ff;
    nxt_alat  = BUS.ale ? BUS.addr[`HBP_REG_MSB:0] : alat_ff;
    hclk_rise = BUS.hclk & ~hclk_q_ff;
  end

  // start decode per bus flavour
  always_comb
  begin
    go       = 1'h0;
    go_rd    = 1'h0;
    go_wrpin = 1'h0;
    case (mode_ff)
      `HBP_MODE_SYNC:
      begin
        go    = sel & ~BUS.rd_n & hclk_rise;
        go_rd = BUS.wr_n;
      end
      `HBP_MODE_ASYNC2:
      begin
        go    = sel & ~BUS.rd_n;
        go_rd = BUS.wr_n;
      end
      default:
      begin
        go       = sel & (~BUS.rd_n | ~BUS.wr_n);
        go_rd    = ~BUS.rd_n;
        go_wrpin = BUS.rd_n;
      end
    endcase
    ended    = BUS.cs_n | (wrpin_ff ? BUS.wr_n : BUS.rd_n);
    ack_tick = (mode_ff != `HBP_MODE_SYNC) | hclk_rise;
  end

  // cycle sequencer next values
  always_comb
  begin
    nxt_state      = state_ff;
    nxt_mode       = mode_ff;
    nxt_mode_taken = 1'h1;
    nxt_wrpin      = wrpin_ff;
    nxt_ack_cnt    = ack_cnt_ff;
    nxt_dout       = dout_ff;
    nxt_doe        = doe_ff;
    nxt_done_n     = done_n_ff;
    nxt_wstb       = 1'h0;
    nxt_waddr      = waddr_ff;
    nxt_wdata      = wdata_ff;
    if (!mode_taken_ff)
    begin
      nxt_mode = BUS.mode_sel;
    end
    case (state_ff)
      DEV_IDLE:
      begin
        if (go && mode_taken_ff)
        begin
          nxt_state   = DEV_ACK;
          nxt_wrpin   = go_wrpin;
          nxt_ack_cnt = `HBP_CNT_RST;
          if (go_rd)
          begin
            nxt_dout = regs[reg_addr];
            nxt_doe  = 1'h1;
          end
          else
          begin
            nxt_wstb  = 1'h1;
            nxt_waddr = reg_addr;
            nxt_wdata = BUS.data_bus;
          end
        end
      end
      DEV_ACK:
      begin
        if (ended)
        begin
          nxt_state = DEV_IDLE;                                      // aborted early
          nxt_doe   = 1'h0;
        end
        else if (ack_tick && (ack_cnt_ff >= 4'(ACK_DLY - 1)))
        begin
          nxt_state  = DEV_HOLD;
          nxt_done_n = 1'h0;
        end
        else if (ack_cnt_ff < 4'(`HBP_ACK_MAX_CYC))
        begin
          nxt_ack_cnt = ack_cnt_ff + 4'h1;
        end
      end
      DEV_HOLD:
      begin
        if (ended)
        begin
          nxt_state  = DEV_IDLE;
          nxt_doe    = 1'h0;
          nxt_done_n = 1'h1;
        end
      end
      default:
      begin
        nxt_state  = DEV_IDLE;
        nxt_doe    = 1'h0;
        nxt_done_n = 1'h1;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RST_N)
    begin
      state_ff      <= DEV_IDLE;
      mode_ff       <= `HBP_MODE_ASYNC;
      mode_taken_ff <= 1'h0;
      alat_ff       <= `HBP_BYTE_RST;
      hclk_q_ff     <= 1'h0;
      wrpin_ff      <= 1'h0;
      ack_cnt_ff    <= `HBP_CNT_RST;
      dout_ff       <= `HBP_BYTE_RST;
      doe_ff        <= 1'h0;
      done_n_ff     <= 1'h1;
      wstb_ff       <= 1'h0;
      waddr_ff      <= `HBP_BYTE_RST;
      wdata_ff      <= `HBP_BYTE_RST;
    end
    else
    begin
      state_ff      <= nxt_state;
      mode_ff       <= nxt_mode;
      mode_taken_ff <= nxt_mode_taken;
      alat_ff       <= nxt_alat;
      hclk_q_ff     <= BUS.hclk;
      wrpin_ff      <= nxt_wrpin;
      ack_cnt_ff    <= nxt_ack_cnt;
      dout_ff       <= nxt_dout;
      doe_ff        <= nxt_doe;
      done_n_ff     <= nxt_done_n;
      wstb_ff       <= nxt_wstb;
      waddr_ff      <= nxt_waddr;
      wdata_ff      <= nxt_wdata;
    end
  end

  // register store write, one cycle after the strobe is taken
  always_ff @(posedge I_REF_CLK)
  begin
    if (wstb_ff)
    begin
      regs[waddr_ff] <= wdata_ff;
    end
  end

  // pins and user side outputs
  assign BUS.done_n   = done_n_ff;
  assign BUS.dev_data = dout_ff;
  assign BUS.dev_oe   = doe_ff;
  assign O_WR_STB     = wstb_ff;
  assign O_WR_ADDR    = waddr_ff;
  assign O_WR_DATA    = wdata_ff;
  assign O_MODE       = mode_ff;

endmodule // hbp_device
`default_nettype wire

// *** hbp_host.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "hbp_defs.svh"
module hbp_host #(
  parameter int CS_STB = `HBP_CS_STB_CYC  // async select-to-strobe wait, cycles
) (
  input  wire logic              I_REF_CLK,  // system clock, 125 MHz
  input  wire logic              I_RST_N,    // synchronous reset, active low
  hbp_bus_if.host                BUS,        // host bus pins
  input  wire hbp_pkg::hbp_mode_t I_MODE,    // bus flavour driven on strap
  input  wire logic              I_REQ,      // request, taken while not busy
  input  wire logic              I_WRITE,    // 1 write, 0 read
  input  wire logic [10:0]       I_ADDR,     // full target address
  input  wire logic [7:0]        I_WDATA,    // write byte
  output logic                   O_BUSY,     // transfer in progress
  output logic                   O_DONE,     // one-cycle pulse at end
  output logic [7:0]             O_RDATA     // read byte
);
  import hbp_pkg::*;

  hbp_host_state_t state_ff;
  hbp_host_state_t nxt_state;
  logic [10:0] addr_ff;
  logic [10:0] nxt_addr;
  logic        cs_n_ff;
  logic        nxt_cs_n;
  logic        ale_ff;
  logic        nxt_ale;
  logic        rd_n_ff;
  logic        nxt_rd_n;
  logic        wr_n_ff;
  logic        nxt_wr_n;
  logic [7:0]  hdata_ff;
  logic [7:0]  nxt_hdata;
  logic        hoe_ff;
  logic        nxt_hoe;
  logic        hclk_ff;
  logic        write_ff;
  logic        nxt_write;
  logic [3:0]  cnt_ff;
  logic [3:0]  nxt_cnt;
  logic        busy_ff;
  logic        nxt_busy;
  logic        done_ff;
  logic        nxt_done;
  logic [7:0]  rdata_ff;
  logic [7:0]  nxt_rdata;
  hbp_mode_t   mode_ff;
  logic        async_mode;

  // transfer sequencer next values
  always_comb
  begin
    nxt_state  = state_ff;
    nxt_addr   = addr_ff;
    nxt_cs_n   = cs_n_ff;
    nxt_ale    = ale_ff;
    nxt_rd_n   = rd_n_ff;
    nxt_wr_n   = wr_n_ff;
    nxt_hdata  = hdata_ff;
    nxt_hoe    = hoe_ff;
    nxt_write  = write_ff;
    nxt_cnt    = cnt_ff;
    nxt_busy   = busy_ff;
    nxt_done   = 1'h0;
    nxt_rdata  = rdata_ff;
    async_mode = (mode_ff == `HBP_MODE_ASYNC);
    case (state_ff)
      HOST_IDLE:
      begin
        if (I_REQ)
        begin
          nxt_state = HOST_LATCH;
          nxt_addr  = I_ADDR;
          nxt_cs_n  = 1'h0;
          nxt_ale   = 1'h1;
          nxt_write = I_WRITE;
          nxt_hdata = I_WDATA;
          nxt_cnt   = `HBP_CNT_RST;
          nxt_busy  = 1'h1;
        end
      end
      HOST_LATCH:
      begin
        nxt_ale  = 1'h0;
        nxt_hoe  = write_ff;
        nxt_wr_n = async_mode | ~write_ff;
        nxt_cnt  = cnt_ff + 4'h1;
        if (!async_mode || (cnt_ff >= 4'(CS_STB - 1)))
        begin
          nxt_state = HOST_STB;
        end
      end
      HOST_STB:
      begin
        nxt_state = HOST_WAIT;
        if (async_mode && write_ff)
        begin
          nxt_wr_n = 1'h0;
        end
        else
        begin
          nxt_rd_n = 1'h0;
        end
      end
      HOST_WAIT:
      begin
        if (!BUS.done_n)
        begin
          nxt_state = HOST_REL;
          nxt_rdata = BUS.data_bus;
          nxt_cs_n  = 1'h1;
          nxt_rd_n  = 1'h1;
          nxt_wr_n  = 1'h1;
          nxt_hoe   = 1'h0;
        end
      end
      HOST_REL:
      begin
        if (BUS.done_n)
        begin
          nxt_state = HOST_IDLE;
          nxt_busy  = 1'h0;
          nxt_done  = 1'h1;
        end
      end
      default:
      begin
        nxt_state = HOST_IDLE;
      end
    endcase
  end

  // sequencer registers; the bus clock is the system clock halved
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RST_N)
    begin
      state_ff <= HOST_IDLE;
      addr_ff  <= `HBP_ADDR_RST;
      cs_n_ff  <= 1'h1;
      ale_ff   <= 1'h0;
      rd_n_ff  <= 1'h1;
      wr_n_ff  <= 1'h1;
      hdata_ff <= `HBP_BYTE_RST;
      hoe_ff   <= 1'h0;
      hclk_ff  <= 1'h0;
      write_ff <= 1'h0;
      cnt_ff   <= `HBP_CNT_RST;
      busy_ff  <= 1'h0;
      done_ff  <= 1'h0;
      rdata_ff <= `HBP_BYTE_RST;
      mode_ff  <= I_MODE;                                            // strap stands through reset
    end
    else
    begin
      state_ff <= nxt_state;
      addr_ff  <= nxt_addr;
      cs_n_ff  <= nxt_cs_n;
      ale_ff   <= nxt_ale;
      rd_n_ff  <= nxt_rd_n;
      wr_n_ff  <= nxt_wr_n;
      hdata_ff <= nxt_hdata;
      hoe_ff   <= nxt_hoe;
      hclk_ff  <= ~hclk_ff;
      write_ff <= nxt_write;
      cnt_ff   <= nxt_cnt;
      busy_ff  <= nxt_busy;
      done_ff  <= nxt_done;
      rdata_ff <= nxt_rdata;
      mode_ff  <= I_MODE;
    end
  end

  // pins and user side outputs
  assign BUS.addr      = addr_ff;
  assign BUS.cs_n      = cs_n_ff;
  assign BUS.ale       = ale_ff;
  assign BUS.rd_n      = rd_n_ff;
  assign BUS.wr_n      = wr_n_ff;
  assign BUS.hclk      = hclk_ff;
  assign BUS.mode_sel  = mode_ff;
  assign BUS.host_data = hdata_ff;
  assign BUS.host_oe   = hoe_ff;
  assign O_BUSY        = busy_ff;
  assign O_DONE        = done_ff;
  assign O_RDATA       = rdata_ff;

endmodule // hbp_host
`default_nettype wire

// *** hbp_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module hbp_monitor #(
  parameter logic [2:0] SEL = 3'h5  // decode value of the watched device
) (
  input wire logic        I_REF_CLK,  // clock
  input wire logic        I_RST_N,    // reset, active low
  input wire logic [10:0] addr,       // address
  input wire logic        cs_n,       // chip select
  input wire logic        rd_n,       // read strobe
  input wire logic        wr_n,       // write strobe or direction
  input wire logic [2:0]  mode_sel,   // strap
  input wire logic        done_n,     // cycle done
  input wire logic [7:0]  dev_data,   // device data
  input wire logic        dev_oe      // device drives data
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);

  // chip decode bits of the address
  logic [2:0] sel_bits;
  assign sel_bits = addr[10:8];

  // done only for a selected, decoded device
  property p_done_sel;
    $fell(done_n) |-> !$past(cs_n) && $past(sel_bits) == SEL;
  endproperty
  a_done_sel: assert property (p_done_sel)
    else $error("done without select");
  // drivers open only on a read strobe under select
  property p_oe_cause;
    $rose(dev_oe) |-> !$past(rd_n) && !$past(cs_n) && $past(sel_bits) == SEL;
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("data drivers opened without read strobe");
  // strobe answered within the bound
  property p_rd_ack;
    $fell(rd_n) && !cs_n && sel_bits == SEL |-> ##[1:14] !done_n;
  endproperty
  a_rd_ack: assert property (p_rd_ack)
    else $error("strobe not acknowledged");
  // async write strobe answered within the bound
  property p_wr_ack;
    $fell(wr_n) && !cs_n && rd_n && mode_sel == 3'h0 && sel_bits == SEL |-> ##[1:14] !done_n;
  endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("write strobe not acknowledged");
  // deselect releases done and data
  property p_cs_rel;
    cs_n[*3] |-> done_n && !dev_oe;
  endproperty
  a_cs_rel: assert property (p_cs_rel)
    else $error("bus not released after deselect");
  // idle strobes release done and data
  property p_stb_rel;
    (rd_n && wr_n)[*3] |-> done_n && !dev_oe;
  endproperty
  a_stb_rel: assert property (p_stb_rel)
    else $error("bus not released after strobe");
  // no device drive during a write
  property p_wr_no_drive;
    !wr_n && !cs_n |-> !dev_oe;
  endproperty
  a_wr_no_drive: assert property (p_wr_no_drive)
    else $error("device drives data in write");
  // read data holds while done is shown
  property p_data_hold;
    !done_n && !$past(done_n) && dev_oe |-> $stable(dev_data);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("read data moved while done");
  // done follows the strobe of the flavour
  property p_done_stb;
    $fell(done_n) |-> !$past(rd_n) || (mode_sel == 3'h0 && !$past(wr_n));
  endproperty
  a_done_stb: assert property (p_done_stb)
    else $error("done without active strobe");
endmodule // hbp_monitor
`default_nettype wire

// *** dual_mode_host_bus_port_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module dual_mode_host_bus_port_tb;
  import hbp_pkg::*;
  localparam logic [2:0] SEL = 3'h5;  // decode value of the answering device
  localparam int LIMIT = 5000;        // cycle ceiling
  logic clk;
  logic rst_n;
  hbp_mode_t mode;
  logic req;
  logic wr;
  logic [10:0] adr;
  logic [7:0] wdat;
  logic done;
  logic busy;
  logic [7:0] rdat;
  logic wstb;
  logic xstb;
  logic [7:0] wa;
  logic [7:0] wd;
  hbp_mode_t omode;
  logic [7:0] mem [0:255];  // model of the register store
  logic [7:0] regs [0:5];
  logic [7:0] exp_a;
  logic [7:0] exp_d;
  hbp_mode_t modes [0:2] = '{3'h0, 3'h1, 3'h7};
  int error_cnt = 0;
  int comparisons = 0;
  int n_wstb = 0;
  int cyc = 0;
  int seed;

  hbp_bus_if bus();
  hbp_bus_if bus_x();

  // second device on a copy of the bus, decoded elsewhere
  assign bus_x.addr = bus.addr;
  assign bus_x.cs_n = bus.cs_n;
  assign bus_x.ale = bus.ale;
  assign bus_x.rd_n = bus.rd_n;
  assign bus_x.wr_n = bus.wr_n;
  assign bus_x.hclk = bus.hclk;
  assign bus_x.mode_sel = bus.mode_sel;
  assign bus_x.host_data = bus.host_data;
  assign bus_x.host_oe = bus.host_oe;

  hbp_host i_hbp_host (.I_REF_CLK(clk), .I_RST_N(rst_n), .BUS(bus), .I_MODE(mode),
    .I_REQ(req), .I_WRITE(wr), .I_ADDR(adr), .I_WDATA(wdat), .O_BUSY(busy),
    .O_DONE(done), .O_RDATA(rdat));
  hbp_device i_hbp_device (.I_REF_CLK(clk), .I_RST_N(rst_n), .BUS(bus), .I_DEV_SEL(SEL),
    .O_WR_STB(wstb), .O_WR_ADDR(wa), .O_WR_DATA(wd), .O_MODE(omode));
  hbp_device i_hbp_device_x (.I_REF_CLK(clk), .I_RST_N(rst_n), .BUS(bus_x),
    .I_DEV_SEL(SEL ^ 3'h2), .O_WR_STB(xstb), .O_WR_ADDR(), .O_WR_DATA(), .O_MODE());
  hbp_monitor #(.SEL(SEL)) i_hbp_monitor (.I_REF_CLK(clk), .I_RST_N(rst_n),
    .addr(bus.addr), .cs_n(bus.cs_n), .rd_n(bus.rd_n), .wr_n(bus.wr_n),
    .mode_sel(bus.mode_sel), .done_n(bus.done_n), .dev_data(bus.dev_data),
    .dev_oe(bus.dev_oe));

  // clock source
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // compare one result
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    begin
      comparisons++;
      if (g !== e)
      begin
        error_cnt++;
        $display("unexpected %s expected %h seen %h", what, e, g);
      end
    end
  endtask

  task automatic tally_and_finish();
    begin
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      error_cnt++;
      $display("unexpected cycle count expected below %0d seen %0d", LIMIT, cyc);
      tally_and_finish();
    end
  end

  // stored bytes and the silence of the other device
  always @(negedge clk)
    if (rst_n)
    begin
      chk("other device idle", 8'h01, {7'h00, bus_x.done_n & ~bus_x.dev_oe & ~xstb});
      if (wstb === 1'b1)
      begin
        n_wstb++;
        chk("write address", exp_a, wa);
        chk("write data", exp_d, wd);
      end
    end

  // one host transfer, checked against the model
  task automatic xfer(input logic w, input logic [7:0] r, input logic [7:0] d);
    int n;
    int k;
    begin
      k = n_wstb;
      wr = w;
      adr = {SEL, r};
      wdat = d;
      exp_a = r;
      exp_d = d;
      req = 1'b1;
      @(negedge clk);
      req = 1'b0;
      chk("busy after take", 8'h01, {7'h00, busy});
      n = 0;
      while (done !== 1'b1 && n < 80)
      begin
        @(negedge clk);
        n++;
      end
      chk("done in time", 8'h01, {7'h00, n < 80});
      chk("busy at done", 8'h00, {7'h00, busy});
      if (w)
      begin
        chk("write count", 8'h01, 8'(n_wstb - k));
        mem[r] = d;
      end
      else
        chk("read data", mem[r], rdat);
    end
  endtask

  // main sequence, one reset per bus flavour
  initial
  begin
    seed = 32'h8be8b557;
    rst_n = 1'b0;
    req = 1'b0;
    wr = 1'b0;
    adr = 11'h000;
    wdat = 8'h00;
    mode = 3'h0;
    exp_a = 8'h00;
    exp_d = 8'h00;
    for (int m = 0; m < 3; m++)
    begin
      @(negedge clk);
      mode = modes[m];
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      chk("captured mode", {5'h00, mode}, {5'h00, omode});
      regs[0] = 8'h00;
      regs[1] = 8'hFF;
      for (int i = 2; i < 6; i++)
        regs[i] = 8'($random(seed));
      for (int i = 0; i < 6; i++)
        xfer(1'b1, regs[i], 8'($random(seed)));
      xfer(1'b1, regs[2], 8'($random(seed)));
      for (int i = 5; i >= 0; i--)
        xfer(1'b0, regs[i], 8'h00);
      $display("bus flavour %0h tests done", mode);
    end
    tally_and_finish();
  end
endmodule // dual_mode_host_bus_port_tb
`default_nettype wire
